//--- dpram_host_pkg.sv
// Constants and types shared by the dual-port memory port controller
// Functional notes
// - Masters avoid same-location access while writing
// - Write data valid setup before write end
// - Write with enable high or write pulse
// - Drive data only after outputs turned off
// - Read needs select, enable low, write high
// - Write line high while address changes
package dpram_host_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 25;

	// ---------------------------------------------------------------
	// Timing figures in ns
	// ---------------------------------------------------------------
	localparam int WRITE_DATA_SETUP_TIME_NS = 10;
	localparam int OUTPUT_OFF_AFTER_ENABLE_DELAY_NS = 10;
	localparam int OUTPUT_OFF_AFTER_WRITE_DELAY_NS = 10;
	localparam int CROSS_PORT_FLOW_DELAY_NS = 25;
	localparam int SELECT_ACCESS_DELAY_NS = 15;
	localparam int ENABLE_ACCESS_DELAY_NS = 10;
	localparam int WRITE_PULSE_NS = 12;

	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// ---------------------------------------------------------------
	// Cycle counts (least times rounded up)
	// ---------------------------------------------------------------
	localparam int OFF_CYCLES = ns_to_cycles(OUTPUT_OFF_AFTER_WRITE_DELAY_NS);
	localparam int SETUP_CYCLES = ns_to_cycles(WRITE_DATA_SETUP_TIME_NS);
	localparam int PULSE_CYCLES = ns_to_cycles(WRITE_PULSE_NS);
	localparam int READ_CYCLES = ns_to_cycles(SELECT_ACCESS_DELAY_NS);
	localparam int FLOW_CYCLES = ns_to_cycles(CROSS_PORT_FLOW_DELAY_NS);
	localparam int CNT_W = 4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic write;
	} mem_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic sel_n;
		logic rw;
		logic oe_n;
	} pin_ctl_t;

endpackage

//--- dpram_port_ctrl.sv
// Host-side controller driving one port of the dual-port static memory
module dpram_port_ctrl
	import dpram_host_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire dpram_host_pkg::mem_req_t req,
	input wire logic req_valid,
	input wire logic other_write_done,
	output logic req_ready,
	output logic [DATA_W-1:0] rdata,
	output logic rdata_valid,
	output logic write_done,
	output dpram_host_pkg::pin_ctl_t pins,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic [DATA_W-1:0] data_in
);

	typedef enum logic [2:0] {
		IDLE,
		RD_WAIT,
		WR_OFF,
		WR_PULSE,
		WR_END
	} state_t;

	state_t state;
	state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	mem_req_t cur;
	mem_req_t next_cur;
	pin_ctl_t next_pins;
	logic [DATA_W-1:0] next_data_out;
	logic next_data_oe_n;
	logic [DATA_W-1:0] next_rdata;
	logic next_rdata_valid;
	logic next_write_done;
	logic next_req_ready;
	logic [DATA_W-1:0] din_meta;
	logic [DATA_W-1:0] din_sync;

	// ---------------------------------------------------------------
	// Data pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			din_meta <= '0;
			din_sync <= '0;
		end else begin
			din_meta <= data_in;
			din_sync <= din_meta;
		end
	end

	// ---------------------------------------------------------------
	// Access sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_cur = cur;
		next_pins = pins;
		next_data_out = data_out;
		next_data_oe_n = data_oe_n;
		next_rdata = rdata;
		next_rdata_valid = 1'b0;
		next_write_done = 1'b0;
		next_req_ready = req_ready;
		unique case (state)
			IDLE: begin
				// Idle port stays deselected so the part powers down
				next_pins.sel_n = 1'b1;
				next_pins.oe_n = 1'b1;
				next_pins.rw = 1'b1;
				next_data_oe_n = 1'b1;
				if (req_valid && req_ready) begin
					next_cur = req;
					next_req_ready = 1'b0;
					// Address moves only with write line high
					next_pins.addr = req.addr;
					next_pins.sel_n = 1'b0;
					if (req.write) begin
						// Enable held high: outputs already off, no bus fight
						next_pins.oe_n = 1'b1;
						next_cnt = CNT_W'(OFF_CYCLES);
						next_state = WR_OFF;
					end else begin
						next_pins.oe_n = 1'b0;
						// Wait access time, and flow time after a far write
						next_cnt = other_write_done ? CNT_W'(FLOW_CYCLES + 1)
							: CNT_W'(READ_CYCLES + 1);
						next_state = RD_WAIT;
					end
				end
			end
			RD_WAIT: begin
				// Two-flop sync adds latency, so count covers it
				if (cnt == '0) begin
					next_rdata = din_sync;
					next_rdata_valid = 1'b1;
					next_pins.sel_n = 1'b1;
					next_pins.oe_n = 1'b1;
					next_req_ready = 1'b1;
					next_state = IDLE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			WR_OFF: begin
				if (cnt <= CNT_W'(1)) begin
					next_pins.rw = 1'b0;
					next_data_out = cur.wdata;
					next_data_oe_n = 1'b0;
					next_cnt = CNT_W'((PULSE_CYCLES > SETUP_CYCLES) ? PULSE_CYCLES
						: SETUP_CYCLES);
					next_state = WR_PULSE;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			WR_PULSE: begin
				if (cnt <= CNT_W'(1)) begin
					// Write line rises first and ends the write
					next_pins.rw = 1'b1;
					next_state = WR_END;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			WR_END: begin
				// Data held one cycle past write end for hold margin
				next_data_oe_n = 1'b1;
				next_pins.sel_n = 1'b1;
				next_write_done = 1'b1;
				next_req_ready = 1'b1;
				next_state = IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= IDLE;
			cnt <= '0;
			cur <= '0;
			pins <= '{addr: '0, sel_n: 1'b1, rw: 1'b1, oe_n: 1'b1};
			data_out <= '0;
			data_oe_n <= 1'b1;
			rdata <= '0;
			rdata_valid <= 1'b0;
			write_done <= 1'b0;
			req_ready <= 1'b1;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			cur <= next_cur;
			pins <= next_pins;
			data_out <= next_data_out;
			data_oe_n <= next_data_oe_n;
			rdata <= next_rdata;
			rdata_valid <= next_rdata_valid;
			write_done <= next_write_done;
			req_ready <= next_req_ready;
		end
	end

endmodule

//--- dpram_port_properties.sv
// Pin order and answer timing checks for the port controller
module dpram_port_properties
	import dpram_host_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire dpram_host_pkg::mem_req_t req,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rdata_valid,
	input wire logic write_done,
	input wire dpram_host_pkg::pin_ctl_t pins,
	input wire logic data_oe_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_idle; req_ready |-> pins.sel_n && pins.oe_n && pins.rw && data_oe_n; endproperty
	a_idle: assert property (p_idle) else $error("idle port active");
	property p_read; !pins.oe_n |-> !pins.sel_n && pins.rw && data_oe_n; endproperty
	a_read: assert property (p_read) else $error("bad read pins");
	property p_drive; !data_oe_n |-> pins.oe_n && !pins.sel_n; endproperty
	a_drive: assert property (p_drive) else $error("drive clash");
	property p_wend; $rose(pins.rw) |-> !data_oe_n && !pins.sel_n; endproperty
	a_wend: assert property (p_wend) else $error("data gone at end");
	property p_wpulse; $fell(pins.rw) |=> $rose(pins.rw); endproperty
	a_wpulse: assert property (p_wpulse) else $error("bad pulse");
	property p_addr; !pins.rw |-> $stable(pins.addr); endproperty
	a_addr: assert property (p_addr) else $error("addr moved");
	property p_rd; req_valid && req_ready && !req.write |-> ##4 rdata_valid; endproperty
	a_rd: assert property (p_rd) else $error("read late");
	property p_wr; req_valid && req_ready && req.write |-> ##[3:6] write_done; endproperty
	a_wr: assert property (p_wr) else $error("write late");
endmodule

//--- sram_model.sv
// Behavioural memory seen from one port
module sram_model
	import dpram_host_pkg::*;
(
	input wire dpram_host_pkg::pin_ctl_t pins,
	input wire logic [DATA_W-1:0] hd,
	input wire logic hoe_n,
	output logic [DATA_W-1:0] bus
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [DATA_W-1:0] mem [4096];
	logic [DATA_W-1:0] last = 8'h00;
	logic rd;
	logic wr_on = 1'b0;
	wire wr = !pins.sel_n && !pins.rw;
	assign #(SELECT_ACCESS_DELAY_NS) rd = !pins.sel_n && !pins.oe_n && pins.rw;
	// Only the end of a real write commits; the drop of wr out of reset does not
	always @(posedge wr) wr_on = 1'b1;
	always @(negedge wr) begin
		if (wr_on)
			mem[pins.addr] = bus;
		wr_on = 1'b0;
	end
	// Released bus shows the inverse, never a stale word
	always @* begin
		bus = !hoe_n ? hd : rd ? mem[pins.addr] : ~last;
		if (!hoe_n || rd) last = bus;
	end
endmodule

//--- tb_top.sv
// Self-checking bench: controller against memory model
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import dpram_host_pkg::*;
	logic mclk = 0, arst_n = 0, req_valid = 0, owd = 0;
	mem_req_t req = '0;
	logic req_ready, rdata_valid, write_done, data_oe_n;
	logic [DATA_W-1:0] rdata, data_out, bus;
	pin_ctl_t pins;
	logic [DATA_W-1:0] exp_mem [int];
	int err_total = 0, total_checks = 0, seed = 72;
	always #12.5 mclk = ~mclk;
	dpram_port_ctrl u_dpram_port_ctrl (.mclk(mclk), .arst_n(arst_n), .req(req),
		.req_valid(req_valid), .other_write_done(owd), .req_ready(req_ready),
		.rdata(rdata), .rdata_valid(rdata_valid), .write_done(write_done), .pins(pins),
		.data_out(data_out), .data_oe_n(data_oe_n), .data_in(bus));
	sram_model u_sram_model (.pins(pins), .hd(data_out), .hoe_n(data_oe_n), .bus(bus));
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		req <= '{a, d, w};
		req_valid <= 1'b1;
		owd <= 1'($random(seed));
		@(posedge mclk);
		req_valid <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while (!(w ? write_done : rdata_valid) && n < 9);
		if (w) begin
			exp_mem[a] = d;
			chk(8'(n), 8'(OFF_CYCLES + ((PULSE_CYCLES > SETUP_CYCLES) ? PULSE_CYCLES
				: SETUP_CYCLES) + 2));
		end else begin
			chk(8'(n), 8'((owd ? FLOW_CYCLES : READ_CYCLES) + 3));
			chk(rdata, exp_mem[a]);
		end
		chk({7'h00, pins.sel_n}, 8'h01);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		logic [ADDR_W-1:0] a;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		op(1, 12'h000, 8'h5A);
		op(1, 12'hFFF, 8'hA5);
		op(0, 12'h000, 8'h00);
		op(0, 12'hFFF, 8'h00);
		$display("corner test done");
		arst_n <= 1'b0;
		@(posedge mclk);
		chk({6'h00, req_ready, pins.sel_n}, 8'h03);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk({6'h00, req_ready, pins.sel_n}, 8'h03);
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			a = ADDR_W'($random(seed));
			op(1, a, 8'($random(seed)));
			op(0, a, 8'h00);
			op(0, a, 8'h00);
		end
		$display("random test done");
		complete_run();
	end
	initial begin
		#50us;
		err_total++;
		complete_run();
	end
endmodule
bind dpram_port_ctrl dpram_port_properties u_dpram_port_properties (.mclk(mclk), .arst_n(arst_n),
	.req(req), .req_valid(req_valid), .req_ready(req_ready), .rdata_valid(rdata_valid),
	.write_done(write_done), .pins(pins), .data_oe_n(data_oe_n));
